/* File: logic/prescaled_downcount_timer.sv */
// 8-bit free-running down-counter with 7-bit prescaler and zero flag
// assumes a byte register port from the core; wait/stop as level inputs
//
// Notes on behaviour
// - prescaler input tick is system clock divided by twelve
// - seven-bit prescaler counts down per input tick while enabled
// - prescaler at zero reloads 7Fh on next advance
// - counter clock chosen from eight prescaler taps, divide 1 to 128
// - counter decrements once per selected counter clock
// - counter at zero reloads FFh, running freely
// - count register readable at any time and writable outside stop mode, write loads directly
// - enable low freezes counter and forces prescaler to 7Fh
// - with enable high, prescaler write loads 0 to 7Fh
// - reset sets counter FFh and prescaler 7Fh
// - decrement to zero sets flag; irq when flag and enable set
// - writing 00h to count or one to status bit 7 sets flag
// - count write beats a simultaneous decrement to zero, no flag
// - timer runs in wait mode; interrupt wakes from wait
// - stop mode freezes all timer registers
//
// Implementation choice: the plain strobed port.
`default_nettype none

module prescaled_downcount_timer
  import tmr_pkg::*;
#(
  parameter int unsigned PRESC_DIV = INT_DIV
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_wait_mode,
  input  wire logic       i_stop_mode,
  output logic [7:0]      o_rdata,
  output logic            o_irq,
  output logic            o_wake
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [6:0]        presc_q;
  logic [7:0]        count_q;
  logic              timer_zero_flag_q;
  logic              timer_irq_enable_q;
  logic              reserved_set_bit_q;
  logic              reserved_clear_bit_q;
  logic              counting_enable_q;
  logic [DSEL_W-1:0] divide_select_q;
  logic [7:0]        rdata_q;

  logic wr_presc;
  logic wr_count;
  logic wr_status;
  logic frozen;

  assign wr_presc  = i_wr && (i_addr == PRESC_OFFSET);
  assign wr_count  = i_wr && (i_addr == COUNT_OFFSET);
  assign wr_status = i_wr && (i_addr == STATUS_OFFSET);
  assign frozen    = i_stop_mode;

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic       presc_tick;
  logic       presc_step;
  logic [6:0] presc_next;
  logic       count_tick;

  tmr_tick_div #(
    .DIV (PRESC_DIV)
  ) u_tick_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n_q),
    .i_hold    (frozen),
    .o_tick    (presc_tick)
  );

  // wait mode does not gate anything here: the timer keeps running
  assign presc_step = presc_tick && counting_enable_q;
  assign presc_next = (presc_q == PRESC_ZERO) ? PRESC_RESET : presc_q - 7'h01;

  always_ff @(posedge i_sys_clk) begin
    if (!rst_n_q) begin
      presc_q <= PRESC_RESET;
    end else if (!frozen) begin
      if (!counting_enable_q) begin
        presc_q <= PRESC_RESET;
      end else if (wr_presc) begin
        presc_q <= i_wdata[6:0];
      end else if (presc_step) begin
        presc_q <= presc_next;
      end
    end
  end

  tmr_tap_sel u_tap_sel (
    .i_presc      (presc_q),
    .i_presc_next (presc_next),
    .i_presc_step (presc_step && !wr_presc),
    .i_dsel       (divide_select_q),
    .o_count_tick (count_tick)
  );

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic       count_dec;
  logic [7:0] count_d;
  logic       hit_zero;

  assign count_dec = count_tick && counting_enable_q;
  assign count_d   = (count_q == COUNT_ZERO) ? COUNT_RESET : count_q - 8'h01;
  // a write in the same cycle wins, so the decrement cannot flag
  assign hit_zero  = count_dec && !wr_count && (count_d == COUNT_ZERO);

  always_ff @(posedge i_sys_clk) begin
    if (!rst_n_q) begin
      count_q <= COUNT_RESET;
    end else if (!frozen) begin
      if (wr_count) begin
        count_q <= i_wdata;
      end else if (count_dec) begin
        count_q <= count_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // status and control
  // ---------------------------------------------------------------
  logic flag_set;

  assign flag_set = hit_zero
                  || (wr_count && i_wdata == COUNT_ZERO)
                  || (wr_status && i_wdata[BIT_ZERO_FLAG]);

  // set beats a software clear landing in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n_q) begin
      timer_zero_flag_q <= STATUS_RESET[BIT_ZERO_FLAG];
    end else if (!frozen) begin
      if (flag_set) begin
        timer_zero_flag_q <= 1'b1;
      end else if (wr_status) begin
        timer_zero_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!rst_n_q) begin
      timer_irq_enable_q   <= STATUS_RESET[BIT_IRQ_EN];
      reserved_set_bit_q   <= STATUS_RESET[BIT_RSV_SET];
      reserved_clear_bit_q <= STATUS_RESET[BIT_RSV_CLR];
      counting_enable_q    <= STATUS_RESET[BIT_CNT_EN];
      divide_select_q      <= STATUS_RESET[DSEL_LSB +: DSEL_W];
    end else if (!frozen && wr_status) begin
      timer_irq_enable_q   <= i_wdata[BIT_IRQ_EN];
      reserved_set_bit_q   <= i_wdata[BIT_RSV_SET];
      reserved_clear_bit_q <= i_wdata[BIT_RSV_CLR];
      counting_enable_q    <= i_wdata[BIT_CNT_EN];
      divide_select_q      <= i_wdata[DSEL_LSB +: DSEL_W];
    end
  end

  // ---------------------------------------------------------------
  // read port and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        PRESC_OFFSET:  rdata_q <= {1'b0, presc_q};
        COUNT_OFFSET:  rdata_q <= count_q;
        STATUS_OFFSET: rdata_q <= {timer_zero_flag_q, timer_irq_enable_q, reserved_set_bit_q,
                                   reserved_clear_bit_q, counting_enable_q, divide_select_q};
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq   = timer_zero_flag_q && timer_irq_enable_q;
  assign o_wake  = o_irq && i_wait_mode;
endmodule : prescaled_downcount_timer

`default_nettype wire

/* File: logic/tmr_pkg.sv */
// constants for the prescaled down-count timer block
// assumes a byte-wide register port driven by the core, one clock domain
`default_nettype none

package tmr_pkg;
  localparam int unsigned SYS_FREQ_MHZ  = 125;
  localparam int unsigned INT_DIV       = 12;
  localparam int unsigned DIV_CNT_W     = 4;
  localparam logic [7:0]  PRESC_OFFSET  = 8'hD2;
  localparam logic [7:0]  COUNT_OFFSET  = 8'hD3;
  localparam logic [7:0]  STATUS_OFFSET = 8'hD4;
  localparam logic [6:0]  PRESC_RESET   = 7'h7F;
  localparam logic [7:0]  COUNT_RESET   = 8'hFF;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  COUNT_ZERO    = 8'h00;
  localparam logic [6:0]  PRESC_ZERO    = 7'h00;
  localparam int unsigned BIT_ZERO_FLAG = 7;
  localparam int unsigned BIT_IRQ_EN    = 6;
  localparam int unsigned BIT_RSV_SET   = 5;
  localparam int unsigned BIT_RSV_CLR   = 4;
  localparam int unsigned BIT_CNT_EN    = 3;
  localparam int unsigned DSEL_LSB      = 0;
  localparam int unsigned DSEL_W        = 3;
endpackage : tmr_pkg

`default_nettype wire

/* File: logic/tmr_tick_div.sv */
// divide-by-N clock enable generator for the prescaler input
// assumes a synchronous active-low reset from the parent
`default_nettype none

module tmr_tick_div
  import tmr_pkg::*;
#(
  parameter int unsigned DIV = INT_DIV
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_hold,
  output logic      o_tick
);
  localparam logic [DIV_CNT_W-1:0] LAST = DIV_CNT_W'(DIV - 1);
  logic [DIV_CNT_W-1:0] cnt_q;

  // stop mode holds the phase so the tick resumes where it left off
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!i_hold) begin
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

  assign o_tick = !i_hold && (cnt_q == LAST);
endmodule : tmr_tick_div

`default_nettype wire

/* File: logic/tmr_tap_sel.sv */
// selects one prescaler tap and turns its rising bit into a counter tick
// assumes the prescaler counts down and moves only on prescaler ticks
`default_nettype none

module tmr_tap_sel
  import tmr_pkg::*;
(
  input  wire logic [6:0]        i_presc,
  input  wire logic [6:0]        i_presc_next,
  input  wire logic              i_presc_step,
  input  wire logic [DSEL_W-1:0] i_dsel,
  output logic                   o_count_tick
);
  logic [7:0] tap_now;
  logic [7:0] tap_next;

  // tap 0 is the prescaler input itself (divide by one)
  assign tap_now  = {i_presc, 1'b0};
  assign tap_next = {i_presc_next, 1'b1};

  // a down-counter bit rising from 0 to 1 marks one period of that tap
  assign o_count_tick = i_presc_step &&
                        (i_dsel == '0 ? 1'b1 : (!tap_now[i_dsel] && tap_next[i_dsel]));
endmodule : tmr_tap_sel

`default_nettype wire

/* File: test/tmr_asserts.sv */
// port-level assertions for the prescaled down-count timer
// assumes it is bound into the timer top and sees only its ports
`default_nettype none

module tmr_asserts
  import tmr_pkg::*;
#(
  parameter int unsigned PRESC_DIV = INT_DIV
) (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_wait_mode,
  input wire logic       i_stop_mode,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       o_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // stop mode drops writes, so only live status writes count
  wire logic st_wr = i_wr && i_addr == STATUS_OFFSET && !i_stop_mode;

  a_wake_follows: assert property (o_wake == (o_irq && i_wait_mode)) else $error("wake mismatch");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
  a_count_readback: assert property (i_wr && i_addr == COUNT_OFFSET && !i_stop_mode ##1 i_rd && i_addr == COUNT_OFFSET
    |=> o_rdata == $past(i_wdata, 2)) else $error("count readback");
  a_presc_msb: assert property (i_rd && i_addr == PRESC_OFFSET |=> !o_rdata[7]) else $error("presc msb");
  a_irq_status: assert property (i_rd && i_addr == STATUS_OFFSET |=> !(o_rdata[7] && o_rdata[6]) || o_irq)
    else $error("irq vs status");
  a_irq_by_write: assert property (st_wr && i_wdata[7] && i_wdata[6] |=> o_irq) else $error("flag write");
  a_irq_off_write: assert property (st_wr && !i_wdata[6] |=> !o_irq) else $error("irq enable");
  a_irq_holds: assert property (o_irq && !st_wr |=> o_irq) else $error("flag cleared");
  a_stop_freeze: assert property (i_stop_mode |=> $stable(o_irq)) else $error("stop freeze");

  c_wake: cover property (o_wake);
  c_flag_write: cover property (st_wr && i_wdata[7]);
  c_stop_run: cover property (i_stop_mode && $past(i_stop_mode));
endmodule : tmr_asserts

bind prescaled_downcount_timer tmr_asserts #(.PRESC_DIV(PRESC_DIV)) tmr_asserts_inst (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake));

`default_nettype wire

/* File: test/test_prescaled_downcount_timer.sv */
// self-checking bench for the prescaled down-count timer
// assumes the package and design are compiled first; no far-side model
`default_nettype none

module test_prescaled_downcount_timer
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  localparam int unsigned DIV = 2; // short divide keeps the run small
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_wait_mode = 1'b0;
  logic        i_stop_mode = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic [7:0]  o_rdata;
  logic [7:0]  d;
  logic [7:0]  v;
  logic        o_irq;
  logic        o_wake;
  logic [31:0] seed = 32'h789B;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          t;

  prescaled_downcount_timer #(.PRESC_DIV(DIV)) prescaled_downcount_timer_inst (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode), .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake));

  always #4 i_sys_clk = ~i_sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // clocks per counter step for a divide select
  function automatic int span(input int s);
    return (1 << s) * DIV;
  endfunction : span

  task automatic chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: mismatch", $time);
    end
  endtask : chk

  // strobes stay up on exit so back-to-back calls never assign twice
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= w;
    @(posedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d === e);
  endtask : rc

  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask : idle

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rc(PRESC_OFFSET, {1'b0, PRESC_RESET});
    rc(COUNT_OFFSET, COUNT_RESET);
    rc(STATUS_OFFSET, STATUS_RESET);
    rc(8'hD5, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wr(COUNT_OFFSET, seed[7:0] | 8'h01);
      rc(COUNT_OFFSET, seed[7:0] | 8'h01);
      wr(STATUS_OFFSET, seed[15:8] & 8'h77);
      rc(STATUS_OFFSET, seed[15:8] & 8'h77);
      wr(PRESC_OFFSET, 8'h05);
      idle(30);
      rc(PRESC_OFFSET, 8'h7F);
      rc(COUNT_OFFSET, seed[7:0] | 8'h01);
    end
    $display("register test done");
    wr(STATUS_OFFSET, 8'h40);
    wr(COUNT_OFFSET, 8'h00);
    idle(1);
    chk(o_irq === 1'b1);
    rc(STATUS_OFFSET, 8'hC0);
    idle(20);
    chk(o_irq === 1'b1);
    wr(STATUS_OFFSET, 8'h40);
    idle(1);
    chk(o_irq === 1'b0);
    wr(STATUS_OFFSET, 8'hC0);
    idle(1);
    chk(o_irq === 1'b1);
    $display("flag test done");
    for (int s = 0; s < 8; s++) begin
      seed = lfsr(seed);
      i_wait_mode <= seed[3];
      wr(STATUS_OFFSET, 8'h00);
      wr(COUNT_OFFSET, 8'h02);
      wr(STATUS_OFFSET, {5'b01001, 3'(s)});
      idle(0);
      t = 0;
      while (o_irq !== 1'b1 && t < 4000) begin
        @(posedge i_sys_clk);
        t++;
      end
      chk(t >= span(s) && t <= 3 * span(s) + DIV + 4);
      chk(o_wake === seed[3]);
      rc(STATUS_OFFSET, {5'b11001, 3'(s)});
      if (s == 7) begin
        idle(span(s));
        rc(COUNT_OFFSET, 8'hFF);
      end
    end
    $display("counting test done");
    seed = lfsr(seed);
    v = {1'b0, seed[6:0] | 7'h02};
    wr(STATUS_OFFSET, 8'h0F);
    wr(PRESC_OFFSET, v);
    rd(PRESC_OFFSET);
    chk(d === v || d === v - 8'h01);
    wr(STATUS_OFFSET, 8'h08);
    i_stop_mode <= 1'b1;
    idle(3);
    rd(COUNT_OFFSET);
    v = d;
    idle(60);
    wr(COUNT_OFFSET, 8'h33);
    rc(COUNT_OFFSET, v);
    i_stop_mode <= 1'b0;
    idle(2);
    $display("stop test done");
    // divide one: rewriting 01 every cycle must hit decrement-to-zero edges
    wr(STATUS_OFFSET, 8'h48);
    repeat (6) wr(COUNT_OFFSET, 8'h01);
    idle(1);
    chk(o_irq === 1'b0);
    idle(4);
    chk(o_irq === 1'b1);
    $display("write race test done");
    tally_and_finish();
  end
endmodule : test_prescaled_downcount_timer

`default_nettype wire
